// >>> rtl/core_sfr_regs.vh
`ifndef CORE_SFR_REGS_VH
`define CORE_SFR_REGS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_STACK_PTR     8'h81
`define ADDR_PTR_LOW       8'h82
`define ADDR_PTR_HIGH      8'h83
`define ADDR_STATUS_WORD   8'hd0
`define ADDR_MAIN_OPERAND  8'he0
`define ADDR_SECOND_OPND   8'hf0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PROGRAM_CNT    16'h0000
`define RST_STACK_PTR      8'h07
`define RST_STATUS_WORD    8'h00
`define RST_DATA_BYTE      8'h00
`define RST_RDATA          8'h00

// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define PSW_CARRY          7
`define PSW_HALF_CARRY     6
`define PSW_USER0          5
`define PSW_BANK_HI        4
`define PSW_BANK_LO        3
`define PSW_SIGNED_WRAP    2
`define PSW_USER1          1
`define PSW_PARITY         0

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_ADD             4'h0
`define OP_ADDC            4'h1
`define OP_SUBB            4'h2
`define OP_PRODUCT         4'h3
`define OP_QUOTIENT        4'h4
`define OP_PUSH            4'h5
`define OP_POP             4'h6
`define OP_PTR_INC         4'h7
`define OP_PTR_LOAD        4'h8
`define OP_MAIN_LOAD       4'h9

// ----------------------------------------------------------------
// miscellaneous constants
// ----------------------------------------------------------------
`define PC_STEP            16'h0001
`define SP_STEP            8'h01
`define PTR_STEP           16'h0001
`define NIBBLE_MAX         5'h0f
`define BYTE_ZERO          8'h00

`endif

// >>> rtl/cpu_core_special_registers.v
// Functional notes
// RQ1 - a 16-bit program counter outside the register space resets to zero.
// RQ2 - the main operand register sits at e0 and takes arithmetic results.
// RQ3 - product puts the low byte in the main and high byte in the second.
// RQ4 - quotient puts the quotient in the main and remainder in the second.
// RQ5 - the second operand register at f0 is plain read/write storage.
// RQ6 - the stack pointer at 81 resets to 07 so the first push hits 08.
// RQ7 - ram 08 to 1f holds banks 1 to 3 and the default stack overlaps it.
// RQ8 - the status word at d0 is read/write and clears to zero on reset.
// RQ9 - bit 7 carry is set on carry out of or borrow into the top bit.
// RQ10 - bit 6 half-carry is set on carry out of or borrow into bit 3.
// RQ11 - bits 4 and 3 pick bank n, whose registers live at 8n to 8n+7.
// RQ12 - bit 0 always shows odd parity of the main operand register.
// RQ13 - the data pointer is 16 bits from a low byte at 82 and high at 83.
// RQ14 - bit 2 flags signed overflow on add, subtract, product and divide; product sets it on a nonzero high byte, divide on a zero divisor.
// RQ15 - push pre-increments the stack pointer and pop post-decrements it.
`timescale 1ns/100ps
`default_nettype none

module cpu_core_special_registers (
    input  wire        core_clk,
    input  wire        rstn,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        op_valid,
    input  wire [3:0]  op_code,
    input  wire [7:0]  op_operand,
    input  wire [15:0] ptr_load_value,
    input  wire        pc_load,
    input  wire [15:0] pc_target,
    input  wire        pc_step,
    input  wire [2:0]  work_reg_sel,
    output wire [7:0]  work_reg_addr,
    output wire [7:0]  stack_ram_addr,
    output wire        stack_ram_wr,
    output wire [15:0] program_counter,
    output wire [7:0]  main_operand_reg,
    output wire [7:0]  second_operand_reg,
    output wire [7:0]  stack_top_pointer,
    output wire [7:0]  program_status_word,
    output wire [15:0] data_pointer
);

`include "core_sfr_regs.vh"

// ----------------------------------------------------------------
// reset release
// ----------------------------------------------------------------
    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_n;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // the registers leave reset on the second edge after rstn rises
    assign rst_n = rst_sync_q;

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
    reg [15:0] pc_q;
    reg [15:0] pc_d;
    reg [7:0]  main_q;
    reg [7:0]  main_d;
    reg [7:0]  second_q;
    reg [7:0]  second_d;
    reg [7:0]  sp_q;
    reg [7:0]  sp_d;
    reg [7:0]  ptr_lo_q;
    reg [7:0]  ptr_lo_d;
    reg [7:0]  ptr_hi_q;
    reg [7:0]  ptr_hi_d;
    // bit 0 of this copy is never used; parity is derived live
    reg [7:0]  psw_q;
    reg [7:0]  psw_d;

// ----------------------------------------------------------------
// arithmetic datapath
// ----------------------------------------------------------------
    wire       carry_in;
    wire [8:0] add_sum;
    wire [4:0] add_nib;
    wire [8:0] sub_diff;
    wire [4:0] sub_nib;
    wire       add_wrap;
    wire       sub_wrap;
    wire       parity;
    wire [7:0] prod_low;
    wire [7:0] prod_high;
    wire       prod_wide;
    wire [7:0] quot;
    wire [7:0] remd;
    wire       div_zero;
    wire [15:0] ptr_next;

    assign carry_in = psw_q[`PSW_CARRY];

    assign add_sum = {1'b0, main_q} + {1'b0, op_operand}
                   + {8'h00, carry_in & (op_code == `OP_ADDC)};
    assign add_nib = {1'b0, main_q[3:0]} + {1'b0, op_operand[3:0]}
                   + {4'h0, carry_in & (op_code == `OP_ADDC)};
    assign sub_diff = {1'b0, main_q} - {1'b0, op_operand}
                    - {8'h00, carry_in};
    assign sub_nib = {1'b0, main_q[3:0]} - {1'b0, op_operand[3:0]}
                   - {4'h0, carry_in};

    // same-sign inputs giving a different-sign sum
    assign add_wrap = (main_q[7] == op_operand[7])
                    && (add_sum[7] != main_q[7]); // RQ14
    // different-sign inputs where the result leaves the minuend sign
    assign sub_wrap = (main_q[7] != op_operand[7])
                    && (sub_diff[7] != main_q[7]); // RQ14

    assign parity = ^main_q; // RQ12

    assign ptr_next = {ptr_hi_q, ptr_lo_q} + `PTR_STEP;

    product_quotient_unit u_prod_quot (
        .opnd_a    (main_q),
        .opnd_b    (second_q),
        .prod_low  (prod_low),
        .prod_high (prod_high),
        .prod_wide (prod_wide),
        .quot      (quot),
        .remd      (remd),
        .div_zero  (div_zero)
    );

// ----------------------------------------------------------------
// next-state logic: operation first, then a register write
// ----------------------------------------------------------------
    wire do_op;
    wire do_wr;

    assign do_op = op_valid;
    assign do_wr = reg_wr;

    always @* begin
        pc_d     = pc_q;
        main_d   = main_q;
        second_d = second_q;
        sp_d     = sp_q;
        ptr_lo_d = ptr_lo_q;
        ptr_hi_d = ptr_hi_q;
        psw_d    = psw_q;

        if (pc_load) begin
            pc_d = pc_target;
        end else if (pc_step) begin
            pc_d = pc_q + `PC_STEP;
        end

        if (do_op) begin
            case (op_code)
                `OP_ADD, `OP_ADDC: begin
                    main_d = add_sum[7:0]; // RQ2
                    psw_d[`PSW_CARRY] = add_sum[8]; // RQ9
                    psw_d[`PSW_HALF_CARRY] = add_nib[4]; // RQ10
                    psw_d[`PSW_SIGNED_WRAP] = add_wrap; // RQ14
                end
                `OP_SUBB: begin
                    main_d = sub_diff[7:0]; // RQ2
                    psw_d[`PSW_CARRY] = sub_diff[8]; // RQ9
                    psw_d[`PSW_HALF_CARRY] = sub_nib[4]; // RQ10
                    psw_d[`PSW_SIGNED_WRAP] = sub_wrap; // RQ14
                end
                `OP_PRODUCT: begin
                    main_d = prod_low; // RQ3
                    second_d = prod_high; // RQ3
                    psw_d[`PSW_CARRY] = 1'b0;
                    psw_d[`PSW_SIGNED_WRAP] = prod_wide; // RQ14
                end
                `OP_QUOTIENT: begin
                    main_d = quot; // RQ4
                    second_d = remd; // RQ4
                    psw_d[`PSW_CARRY] = 1'b0;
                    psw_d[`PSW_SIGNED_WRAP] = div_zero; // RQ14
                end
                `OP_PUSH: begin
                    sp_d = sp_q + `SP_STEP; // RQ15
                end
                `OP_POP: begin
                    sp_d = sp_q - `SP_STEP; // RQ15
                end
                `OP_PTR_INC: begin
                    ptr_lo_d = ptr_next[7:0]; // RQ13
                    ptr_hi_d = ptr_next[15:8]; // RQ13
                end
                `OP_PTR_LOAD: begin
                    ptr_lo_d = ptr_load_value[7:0]; // RQ13
                    ptr_hi_d = ptr_load_value[15:8]; // RQ13
                end
                `OP_MAIN_LOAD: begin
                    main_d = op_operand; // RQ2
                end
                default: begin
                    // unknown codes leave every register as it stands
                    main_d = main_q;
                end
            endcase
        end

        // a register write lands after the operation and wins
        if (do_wr) begin
            case (reg_addr)
                `ADDR_STACK_PTR: begin
                    sp_d = reg_wdata; // RQ6
                end
                `ADDR_PTR_LOW: begin
                    ptr_lo_d = reg_wdata; // RQ13
                end
                `ADDR_PTR_HIGH: begin
                    ptr_hi_d = reg_wdata; // RQ13
                end
                `ADDR_STATUS_WORD: begin
                    psw_d = reg_wdata; // RQ8
                end
                `ADDR_MAIN_OPERAND: begin
                    main_d = reg_wdata; // RQ2
                end
                `ADDR_SECOND_OPND: begin
                    second_d = reg_wdata; // RQ5
                end
                default: begin
                    // unmapped address: the write is dropped
                end
            endcase
        end
    end

// ----------------------------------------------------------------
// register storage
// ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q     <= `RST_PROGRAM_CNT; // RQ1
            main_q   <= `RST_DATA_BYTE;
            second_q <= `RST_DATA_BYTE;
            sp_q     <= `RST_STACK_PTR; // RQ6
            ptr_lo_q <= `RST_DATA_BYTE;
            ptr_hi_q <= `RST_DATA_BYTE;
            psw_q    <= `RST_STATUS_WORD; // RQ8
        end else begin
            pc_q     <= pc_d;
            main_q   <= main_d;
            second_q <= second_d;
            sp_q     <= sp_d;
            ptr_lo_q <= ptr_lo_d;
            ptr_hi_q <= ptr_hi_d;
            psw_q    <= psw_d;
        end
    end

// ----------------------------------------------------------------
// status word view with live parity
// ----------------------------------------------------------------
    wire [7:0] psw_view;

    assign psw_view = {psw_q[7:1], parity}; // RQ12

// ----------------------------------------------------------------
// register read port, data one cycle after the strobe
// ----------------------------------------------------------------
    reg [7:0] rd_sel;

    always @* begin
        case (reg_addr)
            `ADDR_STACK_PTR: begin
                rd_sel = sp_q; // RQ6
            end
            `ADDR_PTR_LOW: begin
                rd_sel = ptr_lo_q; // RQ13
            end
            `ADDR_PTR_HIGH: begin
                rd_sel = ptr_hi_q; // RQ13
            end
            `ADDR_STATUS_WORD: begin
                rd_sel = psw_view; // RQ8
            end
            `ADDR_MAIN_OPERAND: begin
                rd_sel = main_q; // RQ2
            end
            `ADDR_SECOND_OPND: begin
                rd_sel = second_q; // RQ5
            end
            default: begin
                rd_sel = `RST_RDATA;
            end
        endcase
    end

    // read data stands for as long as reg_rd is held, then falls back to zero
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RST_RDATA;
        end else if (reg_rd) begin
            reg_rdata <= rd_sel;
        end else begin
            reg_rdata <= `RST_RDATA;
        end
    end

// ----------------------------------------------------------------
// bank and stack addressing into internal ram
// ----------------------------------------------------------------
    wire [1:0] bank_num;

    assign bank_num = {psw_q[`PSW_BANK_HI], psw_q[`PSW_BANK_LO]};

    // bank n occupies 8n..8n+7; banks 1..3 share 08..1f with the stack
    assign work_reg_addr = {3'b000, bank_num, work_reg_sel}; // RQ11 RQ7

    // push writes at the incremented pointer, pop reads at the current one
    assign stack_ram_wr = do_op && (op_code == `OP_PUSH); // RQ15
    assign stack_ram_addr = stack_ram_wr ? (sp_q + `SP_STEP)
                                         : sp_q; // RQ6 RQ7

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
    assign program_counter     = pc_q; // RQ1
    assign main_operand_reg    = main_q;
    assign second_operand_reg  = second_q;
    assign stack_top_pointer   = sp_q;
    assign program_status_word = psw_view;
    assign data_pointer        = {ptr_hi_q, ptr_lo_q}; // RQ13

endmodule

`default_nettype wire

// >>> rtl/product_quotient_unit.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// unsigned 8x8 product and 8/8 quotient, purely combinational
// ----------------------------------------------------------------
module product_quotient_unit (
    input  wire [7:0] opnd_a,
    input  wire [7:0] opnd_b,
    output wire [7:0] prod_low,
    output wire [7:0] prod_high,
    output wire       prod_wide,
    output wire [7:0] quot,
    output wire [7:0] remd,
    output wire       div_zero
);

`include "core_sfr_regs.vh"

    wire [15:0] product;

    assign product   = {8'h00, opnd_a} * {8'h00, opnd_b};
    assign prod_low  = product[7:0];
    assign prod_high = product[15:8];
    // signed-wrap on product means the high byte is not zero
    assign prod_wide = (product[15:8] != `BYTE_ZERO);

    // divide by zero leaves both operands untouched
    assign div_zero = (opnd_b == `BYTE_ZERO);
    assign quot     = div_zero ? opnd_a : (opnd_a / opnd_b);
    assign remd     = div_zero ? opnd_b : (opnd_a % opnd_b);

endmodule

`default_nettype wire

// >>> tb/cpu_core_special_registers_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "core_sfr_regs.vh"

module cpu_core_special_registers_checker (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        op_valid,
    input wire logic [3:0]  op_code,
    input wire logic [7:0]  op_operand,
    input wire logic [2:0]  work_reg_sel,
    input wire logic [7:0]  work_reg_addr,
    input wire logic [7:0]  stack_ram_addr,
    input wire logic [15:0] program_counter,
    input wire logic [7:0]  main_operand_reg,
    input wire logic [7:0]  second_operand_reg,
    input wire logic [7:0]  stack_top_pointer,
    input wire logic [7:0]  program_status_word,
    input wire logic [15:0] data_pointer
);
    // ----------------------------------------------------------------
    // expected add results, one cycle ahead
    // ----------------------------------------------------------------
    logic [8:0] add_sum;
    logic [4:0] add_nib;
    logic       add_ovf;
    logic       op_go;
    assign add_sum = {1'b0, main_operand_reg} + {1'b0, op_operand};
    assign add_nib = {1'b0, main_operand_reg[3:0]} + {1'b0, op_operand[3:0]};
    assign add_ovf = (main_operand_reg[7] == op_operand[7])
                     && (add_sum[7] != main_operand_reg[7]);
    assign op_go = op_valid && !reg_wr;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    reset_values_a: assert property ($rose(rstn) |->
        program_counter == 16'h0000 && stack_top_pointer == 8'h07
        && program_status_word == 8'h00) else $error("bad reset value");
    parity_live_a: assert property (
        program_status_word[0] == ^main_operand_reg) else $error("parity");
    bank_address_a: assert property (work_reg_addr ==
        {3'h0, program_status_word[4:3], work_reg_sel}) else $error("bank");
    push_pointer_a: assert property (op_go && op_code == `OP_PUSH |->
        stack_ram_addr == stack_top_pointer + 8'h01 ##1
        stack_top_pointer == $past(stack_top_pointer) + 8'h01)
        else $error("push pointer");
    pop_pointer_a: assert property (op_go && op_code == `OP_POP |=>
        stack_top_pointer == $past(stack_top_pointer) - 8'h01)
        else $error("pop pointer");
    product_result_a: assert property (op_go && op_code == `OP_PRODUCT |=>
        {second_operand_reg, main_operand_reg}
        == $past(main_operand_reg) * $past(second_operand_reg)
        && !program_status_word[7]
        && program_status_word[2] == (second_operand_reg != 8'h00))
        else $error("product");
    quotient_result_a: assert property (op_go && op_code == `OP_QUOTIENT
        && second_operand_reg != 8'h00 |=>
        main_operand_reg == $past(main_operand_reg) / $past(second_operand_reg)
        && second_operand_reg
        == $past(main_operand_reg) % $past(second_operand_reg))
        else $error("quotient");
    add_flags_a: assert property (op_go && op_code == `OP_ADD |=>
        main_operand_reg == $past(add_sum[7:0])
        && program_status_word[7] == $past(add_sum[8])
        && program_status_word[6] == $past(add_nib[4])
        && program_status_word[2] == $past(add_ovf)) else $error("add");
    read_main_a: assert property (reg_rd && reg_addr == `ADDR_MAIN_OPERAND
        |=> reg_rdata == $past(main_operand_reg)) else $error("read main");
    read_pointer_a: assert property (reg_rd && reg_addr == `ADDR_PTR_HIGH
        |=> reg_rdata == $past(data_pointer[15:8])) else $error("read ptr");
    read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");

    cover property (op_go && op_code == `OP_PRODUCT);
    cover property (op_go && op_code == `OP_PUSH);
    cover property (reg_rd && reg_addr == `ADDR_PTR_HIGH);
endmodule

bind cpu_core_special_registers cpu_core_special_registers_checker chk (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op_code(op_code), .op_operand(op_operand), .work_reg_sel(work_reg_sel),
    .work_reg_addr(work_reg_addr), .stack_ram_addr(stack_ram_addr),
    .program_counter(program_counter), .main_operand_reg(main_operand_reg),
    .second_operand_reg(second_operand_reg), .data_pointer(data_pointer),
    .stack_top_pointer(stack_top_pointer),
    .program_status_word(program_status_word));

`default_nettype wire

// >>> tb/cpu_core_special_registers_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "core_sfr_regs.vh"

module cpu_core_special_registers_bench;
    logic        core_clk, rstn, reg_wr, reg_rd, op_valid, pc_load, pc_step;
    logic        stack_ram_wr, ram_w;
    logic [7:0]  reg_addr, reg_wdata, op_operand, reg_rdata, work_reg_addr;
    logic [7:0]  stack_ram_addr, main_operand_reg, second_operand_reg, ram_a;
    logic [7:0]  stack_top_pointer, program_status_word;
    logic [3:0]  op_code;
    logic [2:0]  work_reg_sel;
    logic [15:0] ptr_load_value, pc_target, program_counter, data_pointer;
    int          failures, n_compared;

    cpu_core_special_registers DUT (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code),
        .op_operand(op_operand), .ptr_load_value(ptr_load_value),
        .pc_load(pc_load), .pc_target(pc_target), .pc_step(pc_step),
        .work_reg_sel(work_reg_sel), .work_reg_addr(work_reg_addr),
        .stack_ram_addr(stack_ram_addr), .stack_ram_wr(stack_ram_wr),
        .program_counter(program_counter), .main_operand_reg(main_operand_reg),
        .second_operand_reg(second_operand_reg),
        .stack_top_pointer(stack_top_pointer),
        .program_status_word(program_status_word), .data_pointer(data_pointer));

    // ----------------------------------------------------------------
    // bus and operation tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask

    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic reset_dut;
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
        @(posedge core_clk);
    endtask

    // ram strobe and address are captured while the request stands
    task automatic op(input logic [3:0] c, input logic [7:0] v);
        op_code <= c;
        op_operand <= v;
        op_valid <= 1'b1;
        #1 ram_a = stack_ram_addr;
        ram_w = stack_ram_wr;
        @(posedge core_clk);
        op_valid <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic arith(input logic [3:0] c, input logic [7:0] a,
                         input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] n;
        logic       k;
        logic       v;
        k = (c == `OP_ADD) ? 1'b0 : ci;
        if (c == `OP_SUBB) begin
            s = {1'b0, a} - {1'b0, b} - k;
            n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - k;
            v = (a[7] != b[7]) && (s[7] != a[7]);
        end else begin
            s = {1'b0, a} + {1'b0, b} + k;
            n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + k;
            v = (a[7] == b[7]) && (s[7] != a[7]);
        end
        wr(`ADDR_STATUS_WORD, {ci, 7'h00});
        op(`OP_MAIN_LOAD, a);
        op(c, b);
        check(main_operand_reg, s[7:0]);
        check(program_status_word, {s[8], n[4], 3'h0, v, 1'b0, ^s[7:0]});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rstn, reg_wr, reg_rd, op_valid, pc_load, pc_step} = 6'h00;
        {reg_addr, reg_wdata, op_operand, op_code} = 28'h0;
        {ptr_load_value, pc_target, work_reg_sel} = 35'h0;
        failures = 0;
        n_compared = 0;
        reset_dut;
        check(program_counter, 16'h0000);
        rd(`ADDR_STACK_PTR, 8'h07);
        rd(`ADDR_STATUS_WORD, 8'h00);
        rd(8'h84, 8'h00);
        pc_step <= 1'b1;
        @(posedge core_clk);
        pc_load <= 1'b1;
        pc_target <= 16'hffff;
        @(posedge core_clk);
        pc_load <= 1'b0;
        @(posedge core_clk);
        pc_step <= 1'b0;
        #1 check(program_counter, 16'h0000);
        @(posedge core_clk);
        wr(`ADDR_MAIN_OPERAND, 8'h5b);
        rd(`ADDR_MAIN_OPERAND, 8'h5b);
        wr(`ADDR_STATUS_WORD, 8'hfe);
        rd(`ADDR_STATUS_WORD, 8'hff);
        wr(`ADDR_MAIN_OPERAND, 8'h00);
        rd(`ADDR_STATUS_WORD, 8'hfe);
        wr(`ADDR_SECOND_OPND, 8'ha5);
        rd(`ADDR_SECOND_OPND, 8'ha5);
        for (int n = 0; n < 4; n++) begin
            work_reg_sel <= 3'(2 * n + 1);
            wr(`ADDR_STATUS_WORD, 8'(n << 3));
            check(work_reg_addr, 16'(10 * n + 1));
        end
        op(`OP_PUSH, 8'h00);
        check({ram_w, ram_a}, 16'h0108);
        check(stack_top_pointer, 8'h08);
        op(`OP_POP, 8'h00);
        check({ram_w, ram_a}, 16'h0008);
        check(stack_top_pointer, 8'h07);
        arith(`OP_ADD, 8'h7f, 8'h01, 1'b1);
        arith(`OP_ADD, 8'hff, 8'h01, 1'b0);
        arith(`OP_ADDC, 8'h0e, 8'h01, 1'b1);
        arith(`OP_ADDC, 8'h80, 8'h80, 1'b1);
        arith(`OP_SUBB, 8'h10, 8'h01, 1'b0);
        arith(`OP_SUBB, 8'h80, 8'h01, 1'b1);
        arith(`OP_SUBB, 8'h00, 8'h00, 1'b1);
        wr(`ADDR_STATUS_WORD, 8'h00);
        wr(`ADDR_SECOND_OPND, 8'h11);
        op(`OP_MAIN_LOAD, 8'hf0);
        op(`OP_PRODUCT, 8'h00);
        check({second_operand_reg, main_operand_reg}, 16'h0ff0);
        check(program_status_word, 8'h04);
        op(`OP_MAIN_LOAD, 8'hc8);
        wr(`ADDR_SECOND_OPND, 8'h07);
        op(`OP_QUOTIENT, 8'h00);
        check({second_operand_reg, main_operand_reg}, 16'h041c);
        check(program_status_word, 8'h01);
        wr(`ADDR_SECOND_OPND, 8'h00);
        op(`OP_QUOTIENT, 8'h00);
        check({second_operand_reg, main_operand_reg}, 16'h001c);
        check(program_status_word, 8'h05);
        wr(`ADDR_PTR_LOW, 8'hff);
        wr(`ADDR_PTR_HIGH, 8'h12);
        op(`OP_PTR_INC, 8'h00);
        check(data_pointer, 16'h1300);
        ptr_load_value <= 16'hbeef;
        op(`OP_PTR_LOAD, 8'h00);
        rd(`ADDR_PTR_LOW, 8'hef);
        rd(`ADDR_PTR_HIGH, 8'hbe);
        wr(`ADDR_STACK_PTR, 8'h40);
        check(stack_top_pointer, 8'h40);
        pc_target <= 16'h1234;
        pc_load <= 1'b1;
        @(posedge core_clk);
        pc_load <= 1'b0;
        reset_dut;
        check(program_counter, 16'h0000);
        check(program_status_word, 8'h00);
        rd(`ADDR_STACK_PTR, 8'h07);
        complete_run;
    end
endmodule

`default_nettype wire
